// *** squib_driver_reset_control.v ***
// reset supervisor for an eight-channel squib driver
// assumes all monitor inputs are asynchronous comparator levels and are synchronised here;
// arm_fire_start is a same-clock pulse from the command logic
`timescale 1ns/10ps
`include "reset_control_consts.vh"
module squib_driver_reset_control #(
    parameter [17:0] supply_filter_cycles = `SUPPLY_FILTER_CYC,
    parameter [17:0] deglitch_cycles = `DEGLITCH_CYC,
    parameter [17:0] deploy_cycles = `DEPLOY_CYC
) (
    // clock and power-up reset
    input wire clk,
    input wire rst_n,
    // supply, reference and ground monitors, high means fault
    input wire supply_low_level_one,
    input wire supply_low_level_two,
    input wire ref_resistance_upper_limit,
    input wire ref_resistance_lower_limit,
    input wire logic_ground_lost,
    input wire analog_ground_lost,
    // host reset pin, active low
    input wire ext_reset_low_in,
    // deployment control
    input wire arm_fire_start,
    input wire [7:0] channel_power_ground_open,
    input wire [7:0] high_side_request,
    input wire [7:0] low_side_request,
    // outputs
    output reg internal_reset_n,
    output reg deploy_active,
    output wire [7:0] high_side_output,
    output wire [7:0] low_side_output,
    output reg [7:0] low_side_diag_fail,
    output reg analog_meas_pullup
);
    reg [5:0] sync1;
    reg [5:0] sync2;
    reg [7:0] gnd_s1;
    reg [7:0] gnd_s2;
    reg [17:0] filter_cnt;
    reg supply_one_fault;
    reg [17:0] glitch_cnt;
    reg ext_asserted;
    reg [17:0] deploy_cnt;
    reg rst_meta;
    wire [5:0] raw_in;
    wire instant_fault;
    wire reset_cause;
    wire ext_low;
    wire supply_one_s;
    wire supply_two_s;
    wire ref_out_s;
    wire logic_gnd_s;
    wire analog_gnd_s;
    wire ext_cause;
    reg [7:0] high_side_drive;
    reg [7:0] low_side_drive;
    reg deploy_state;
    reg next_deploy_state;

    // one-bit deploy state; codes are binary
    localparam DEPLOY_IDLE = 1'b0;
    localparam DEPLOY_RUN = 1'b1;

    assign raw_in = {supply_low_level_one, supply_low_level_two,
                     ref_resistance_upper_limit | ref_resistance_lower_limit,
                     logic_ground_lost, analog_ground_lost, ~ext_reset_low_in};

    // two-flop synchronisers, one per monitor; cleared to the idle level
    // so that no false reset cause follows power-up
    genvar m;
    generate
        for (m = 0; m < `MONITORS; m = m + 1) begin : mon
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[m] <= 1'b0;
                    sync2[m] <= 1'b0;
                end else begin
                    sync1[m] <= raw_in[m];
                    sync2[m] <= sync1[m];
                end
            end
        end
    endgenerate
    assign ext_low = sync2[0];
    assign analog_gnd_s = sync2[1];
    assign logic_gnd_s = sync2[2];
    assign ref_out_s = sync2[3];
    assign supply_two_s = sync2[4];
    assign supply_one_s = sync2[5];

    // supply level one must stay low for the whole filter time
    // counter saturates, so the fault stands as long as the level does
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_cnt <= 18'h00000;
            supply_one_fault <= 1'b0;
        end else if (!supply_one_s) begin
            filter_cnt <= 18'h00000;
            supply_one_fault <= 1'b0;
        end else if (filter_cnt >= supply_filter_cycles - 18'h00001) begin
            supply_one_fault <= 1'b1;
        end else begin
            filter_cnt <= filter_cnt + 18'h00001;
        end
    end

    // deglitch external reset; short pulses never reach ext_asserted
    // a held pin keeps ext_asserted up until it is released
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            glitch_cnt <= 18'h00000;
            ext_asserted <= 1'b0;
        end else if (!ext_low) begin
            glitch_cnt <= 18'h00000;
            ext_asserted <= 1'b0;
        end else if (glitch_cnt >= deglitch_cycles - 18'h00001) begin
            ext_asserted <= 1'b1;
        end else begin
            glitch_cnt <= glitch_cnt + 18'h00001;
        end
    end

    // deploy timer runs from arm-fire until expiry; arm-fire while running is ignored
    always @* begin
        next_deploy_state = deploy_state;
        case (deploy_state)
            DEPLOY_IDLE: begin
                if (arm_fire_start) begin
                    next_deploy_state = DEPLOY_RUN;
                end
            end
            DEPLOY_RUN: begin
                if (deploy_cnt >= deploy_cycles - 18'h00001) begin
                    next_deploy_state = DEPLOY_IDLE;
                end
            end
            default: begin
                next_deploy_state = DEPLOY_IDLE;
            end
        endcase
    end

    // cleared by the internal reset, so a supply fault ends a deployment
    always @(posedge clk or negedge internal_reset_n) begin
        if (!internal_reset_n) begin
            deploy_state <= DEPLOY_IDLE;
            deploy_cnt <= 18'h00000;
            deploy_active <= 1'b0;
        end else begin
            deploy_state <= next_deploy_state;
            deploy_active <= (next_deploy_state == DEPLOY_RUN);
            if (deploy_state == DEPLOY_RUN && next_deploy_state == DEPLOY_RUN) begin
                deploy_cnt <= deploy_cnt + 18'h00001;
            end else begin
                deploy_cnt <= 18'h00000;
            end
        end
    end

    // supply, reference and ground faults act even mid-deployment
    assign instant_fault = supply_two_s | ref_out_s
                         | logic_gnd_s | analog_gnd_s;
    // ext reset masked while deploying; a held one takes effect on completion
    assign ext_cause = ext_asserted & ~deploy_active;
    // supply faults are never masked, so they cut a deployment short
    assign reset_cause = supply_one_fault | instant_fault | ext_cause;

    // async assert, two-stage synchronous release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            internal_reset_n <= 1'b0;
        end else if (reset_cause) begin
            rst_meta <= 1'b0;
            internal_reset_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            internal_reset_n <= rst_meta;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_meas_pullup <= 1'b0;
        end else begin
            analog_meas_pullup <= analog_gnd_s;
        end
    end

    // per-channel gating; each channel sees only its own ground
    genvar i;
    generate
        for (i = 0; i < `CHANNELS; i = i + 1) begin : chan
            // ground-open sense is a pin level, so it is synchronised per channel
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    gnd_s1[i] <= 1'b0;
                    gnd_s2[i] <= 1'b0;
                end else begin
                    gnd_s1[i] <= channel_power_ground_open[i];
                    gnd_s2[i] <= gnd_s1[i];
                end
            end
            // drivers drop at once with the internal reset, follow requests a cycle late
            always @(posedge clk or negedge internal_reset_n) begin
                if (!internal_reset_n) begin
                    high_side_drive[i] <= 1'b0;
                    low_side_drive[i] <= 1'b0;
                    low_side_diag_fail[i] <= 1'b0;
                end else begin
                    high_side_drive[i] <= high_side_request[i];
                    low_side_drive[i] <= low_side_request[i] & ~gnd_s2[i];
                    low_side_diag_fail[i] <= gnd_s2[i];
                end
            end
        end
    endgenerate
    assign high_side_output = high_side_drive;
    assign low_side_output = low_side_drive;
endmodule

// *** reset_control_consts.vh ***
// constants for the squib driver reset supervisor
// assumes a single 100 MHz clock; analog monitors arrive as raw comparator levels
`ifndef RESET_CONTROL_CONSTS_VH
`define RESET_CONTROL_CONSTS_VH
`define CLK_PERIOD_NS 10
`define SUPPLY_FILTER_NS 20000
// cycle counts are sized to the 18-bit counters, ns figure over the 10 ns period
`define SUPPLY_FILTER_CYC 18'h007d0
`define DEGLITCH_NS 10000
`define DEGLITCH_CYC 18'h003e8
`define DEPLOY_NS 2150000
`define DEPLOY_CYC 18'h347d8
`define CNT_W 18
`define CHANNELS 8
`define MONITORS 6
`endif

// *** reset_ctl_checker.sv ***
// port assertions for the reset supervisor
// assumes deploy_cycles of at least 8
`timescale 1ns/10ps
module reset_ctl_checker (
    // clock and reset
    input wire clk, input wire rst_n,
    // causes and requests
    input wire supply_low_level_two, input wire ref_resistance_upper_limit,
    input wire ref_resistance_lower_limit, input wire logic_ground_lost,
    input wire analog_ground_lost, input wire arm_fire_start,
    input wire [7:0] high_side_request,
    // outputs
    input wire internal_reset_n, input wire deploy_active,
    input wire [7:0] high_side_output, input wire [7:0] low_side_output
);
    wire in_rst = !internal_reset_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_lvl_two: assert property ($rose(supply_low_level_two) |-> ##[1:4] in_rst)
        else $error("level two missed");
    chk_ref_range: assert property (
        $rose(ref_resistance_upper_limit | ref_resistance_lower_limit)
        |-> ##[1:4] in_rst) else $error("ref range missed");
    chk_logic_gnd: assert property ($rose(logic_ground_lost) |-> ##[1:4] in_rst)
        else $error("logic ground missed");
    chk_analog_gnd: assert property ($rose(analog_ground_lost) |-> ##[1:4] in_rst)
        else $error("analog ground missed");
    chk_hs_off: assert property (in_rst |-> high_side_output == 8'h00)
        else $error("high side on in reset");
    chk_ls_off: assert property (in_rst |-> low_side_output == 8'h00)
        else $error("low side on in reset");
    chk_hs_follow: assert property (!in_rst && $past(!in_rst)
        |-> high_side_output == $past(high_side_request)) else $error("high side mismatch");
    chk_arm_take: assert property (
        arm_fire_start && !in_rst && !deploy_active |=> deploy_active)
        else $error("deploy not started");
    chk_deploy_hold: assert property ($rose(deploy_active) |-> deploy_active[*8])
        else $error("deploy too short");
endmodule
bind squib_driver_reset_control reset_ctl_checker u_reset_ctl_checker (.*);

// *** host_reset_pin.sv ***
// host model driving the external reset pin
// assumes calls land just after a rising edge
`timescale 1ns/10ps
module host_reset_pin (
    // pin, idles high as with the pull-up
    output reg ext_reset_low_in
);
    initial ext_reset_low_in = 1'b1;
    task drive(input v);
        ext_reset_low_in = v;
    endtask
endmodule

// *** tb.sv ***
// bench for the reset supervisor
// assumes short sim counts: filter 4, deglitch 4, deploy 20
`timescale 1ns/10ps
module tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg arm = 1'b0;
    reg [5:0] flt = 6'h00;
    reg [7:0] gnd = 8'h00;
    reg [7:0] req = 8'hff;
    wire ext_n, irn, dep, pull;
    wire [7:0] hs, ls, diag;
    integer err_count = 0;
    integer checks = 0;
    integer i;
    always #5 clk = ~clk;
    host_reset_pin u_host_reset_pin (.ext_reset_low_in(ext_n));
    squib_driver_reset_control #(.supply_filter_cycles(18'h4), .deglitch_cycles(18'h4),
        .deploy_cycles(18'h14)) u_squib_driver_reset_control (.clk(clk), .rst_n(rst_n),
        .supply_low_level_one(flt[0]), .supply_low_level_two(flt[1]),
        .ref_resistance_upper_limit(flt[2]), .ref_resistance_lower_limit(flt[3]),
        .logic_ground_lost(flt[4]), .analog_ground_lost(flt[5]), .ext_reset_low_in(ext_n),
        .arm_fire_start(arm), .channel_power_ground_open(gnd), .high_side_request(req),
        .low_side_request(req), .internal_reset_n(irn), .deploy_active(dep),
        .high_side_output(hs), .low_side_output(ls), .low_side_diag_fail(diag),
        .analog_meas_pullup(pull));
    task cyc(input integer n);
        begin repeat (n) @(posedge clk); #1; end
    endtask
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task pin(input v, input integer n);
        begin u_host_reset_pin.drive(v); cyc(n); end
    endtask
    task end_of_test;
        begin
            $display("checks %0d errors %0d", checks, err_count);
            if (err_count == 0 && checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task t_faults;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                flt = 6'h01 << i;
                cyc(10);
                chk("fault", {6'h00, irn, pull}, {6'h00, 1'b0, i == 5});
                chk("drivers off", hs | ls, 8'h00);
                flt = 6'h00;
                cyc(6);
                chk("release", {7'h00, irn}, 8'h01);
            end
            flt = 6'h01;
            cyc(2);
            flt = 6'h00;
            cyc(6);
            chk("short supply dip", {7'h00, irn}, 8'h01);
            $display("fault test done");
        end
    endtask
    task t_ext;
        begin
            pin(1'b0, 2);
            pin(1'b1, 6);
            chk("glitch", {7'h00, irn}, 8'h01);
            pin(1'b0, 10);
            chk("ext reset", {7'h00, irn}, 8'h00);
            pin(1'b1, 6);
            $display("ext test done");
        end
    endtask
    task t_deploy;
        begin
            arm = 1'b1;
            cyc(1);
            arm = 1'b0;
            pin(1'b0, 12);
            chk("ext in deploy", {6'h00, dep, irn}, 8'h03);
            cyc(14);
            chk("ext after deploy", {6'h00, dep, irn}, 8'h00);
            pin(1'b1, 6);
            arm = 1'b1;
            cyc(1);
            arm = 1'b0;
            cyc(10);
            flt = 6'h02;
            cyc(5);
            chk("supply in deploy", {6'h00, dep, irn}, 8'h00);
            flt = 6'h00;
            cyc(6);
            $display("deploy test done");
        end
    endtask
    task t_gnd;
        begin
            gnd = 8'h08;
            req = 8'hff;
            cyc(5);
            chk("low side", ls, 8'hf7);
            chk("high side", hs, 8'hff);
            chk("diag", diag, 8'h08);
            $display("ground test done");
        end
    endtask
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(5);
        t_faults;
        t_ext;
        t_deploy;
        t_gnd;
        end_of_test;
    end
    initial begin
        #20000;
        err_count = err_count + 1;
        end_of_test;
    end
endmodule
